// ===== logic/asc_cfg.svh
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// ==========================================================
// Register word indices (byte address is four times these)
`define ASC_IDX_CTL1   6'h13
`define ASC_IDX_CTL2   6'h14
`define ASC_IDX_CTL3   6'h15
`define ASC_IDX_STS1   6'h16
`define ASC_IDX_DATA   6'h18

// ==========================================================
// Control one bit positions
`define ASC_C1_LOOP    7
`define ASC_C1_EN      6
`define ASC_C1_INV     5
`define ASC_C1_NINE    4
`define ASC_C1_WAKE    3
`define ASC_C1_ILTY    2
`define ASC_C1_PON     1
`define ASC_C1_PODD    0

// ==========================================================
// Control two bit positions
`define ASC_C2_TXE_IE  7
`define ASC_C2_TXD_IE  6
`define ASC_C2_RXF_IE  5
`define ASC_C2_IDL_IE  4
`define ASC_C2_TXON    3
`define ASC_C2_RXON    2
`define ASC_C2_STBY    1
`define ASC_C2_BRK     0

// ==========================================================
// Control three bit positions and writable mask
`define ASC_C3_R8      7
`define ASC_C3_T8      6
`define ASC_C3_WMASK   8'h4F

// ==========================================================
// Status one bit positions
`define ASC_S1_TXE     7
`define ASC_S1_TC      6
`define ASC_S1_RXF     5
`define ASC_S1_IDLE    4
`define ASC_S1_OR      3
`define ASC_S1_NF      2
`define ASC_S1_FE      1
`define ASC_S1_PE      0

// ==========================================================
// Reset values
`define ASC_S1_RESET   8'hC0
`define ASC_CTL_RESET  8'h00

// ==========================================================
// Timing: bus clocks per serial bit, frame lengths in bits
`define ASC_BIT_CYC    5'h10
`define ASC_HALF_CYC   5'h08
`define ASC_LEN_SHORT  4'hA
`define ASC_LEN_LONG   4'hB

`endif

// ===== logic/asc_pkg.sv
package asc_pkg;

   typedef enum logic [0:0] {
      TX_IDLE = 1'b0,
      TX_BUSY = 1'b1
   } asc_tx_state_e;

   typedef enum logic [0:0] {
      RX_IDLE = 1'b0,
      RX_DATA = 1'b1
   } asc_rx_state_e;

   typedef struct packed {
      logic [7:0]    ctl1;
      logic [7:0]    ctl2;
      logic [7:0]    ctl3;
      logic [7:0]    status;
      logic [7:0]    arm;
      logic [7:0]    tx_buf;
      logic [7:0]    rx_buf;
      logic          tx_ever;
      logic          pend_pre;
      logic          brk_tail;
      logic          tx_is_brk;
      asc_tx_state_e tx_state;
      logic [10:0]   tx_sh;
      logic [3:0]    tx_left;
      logic [4:0]    baud;
      asc_rx_state_e rx_state;
      logic [4:0]    rx_cnt;
      logic [3:0]    rx_bits;
      logic [9:0]    rx_sh;
      logic [1:0]    vote;
      logic          rx_noise;
      logic [3:0]    ones;
      logic          idle_arm;
      logic [31:0]   prdata;
      logic          pready;
      logic          pslverr;
      logic          serial_out;
      logic          irq_tx;
      logic          irq_rx;
      logic          irq_err;
   } asc_state_s;

endpackage

// ===== logic/asc_serial_ctrl.sv
`timescale 1ns/1ns
`include "asc_cfg.svh"

// Functional notes
// RULE_01: Parity bit odd when select set, else even
// RULE_02: Frames are ten or eleven bits long
// RULE_03: Software keeps parity select stable mid-character
// RULE_04: Transmit-empty interrupt only while enabled
// RULE_05: Transmit-done interrupt only while enabled
// RULE_06: Receive-full and idle interrupts need enables
// RULE_07: Enabling transmitter sends all-ones preamble first
// RULE_08: Disabling transmitter finishes current character
// RULE_09: Toggling transmitter enable queues idle character
// RULE_10: Software never writes enables while block off
// RULE_11: Receiver disable leaves receive flags alone
// RULE_12: Standby masks receive interrupts; wake clears it
// RULE_13: Break bit sends break, then one high
// RULE_14: Software waits before toggling break bit
// RULE_15: Received ninth bit stored, mirrors bit seven
// RULE_16: Ninth transmit bit loads with buffer data
// RULE_17: Error interrupt needs each flag's own enable
// RULE_18: Empty flag sets on load, cleared by sequence
// RULE_19: First transmitter enable sets empty flag
// RULE_20: Done flag means empty and line idle
// RULE_21: Receive-full set on transfer, cleared by sequence
// RULE_22: Idle flag needs character since last clear
// RULE_23: Block disable sets empty and done flags
// RULE_24: Wake select picks address mark or idle
// RULE_25: Overrun clears only after armed status read
// RULE_26: Interrupt outputs are OR of enabled flags
module asc_serial_ctrl (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial line
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   // Interrupt requests
   output logic             irq_tx,
   output logic             irq_rx,
   output logic             irq_err
);

   // ==========================================================
   // State
   asc_pkg::asc_state_s s;
   asc_pkg::asc_state_s next_s;

   logic [5:0]  idx;
   logic        acc;
   logic        en;
   logic        inv;
   logic        nine;
   logic        odd;
   logic        pon;
   logic        tick;
   logic [3:0]  flen;
   logic [3:0]  frame_len;
   logic [10:0] fr;
   logic [10:0] data_fr;
   logic        have;
   logic        tx_load;
   logic        rx_xfer;
   logic        rxd;
   logic        maj;
   logic        noisy;
   logic [2:0]  smp;
   logic [8:0]  d;
   logic        msb;
   logic        woke;
   logic        stby;

   assign prdata         = s.prdata;
   assign pready         = s.pready;
   assign pslverr        = s.pslverr;
   assign serial_out_pin = s.serial_out;
   assign irq_tx         = s.irq_tx;
   assign irq_rx         = s.irq_rx;
   assign irq_err        = s.irq_err;

   // ==========================================================
   // Next state
   always_comb begin
      next_s  = s;
      idx     = paddr[7:2];
      acc     = psel && penable && s.pready;
      en      = s.ctl1[`ASC_C1_EN];
      inv     = s.ctl1[`ASC_C1_INV];
      nine    = s.ctl1[`ASC_C1_NINE];
      odd     = s.ctl1[`ASC_C1_PODD];
      pon     = s.ctl1[`ASC_C1_PON];
      frame_len = nine ? `ASC_LEN_LONG : `ASC_LEN_SHORT; // see RULE_02
      tick    = en && (s.baud == `ASC_BIT_CYC - 5'h01);
      tx_load = 1'b0;
      rx_xfer = 1'b0;
      have    = 1'b0;
      flen    = frame_len;
      fr      = 11'h7FF;
      woke    = 1'b0;
      msb     = 1'b0;
      rxd     = s.ctl1[`ASC_C1_LOOP] ? s.serial_out : serial_in_pin;
      smp     = {s.vote, rxd};
      maj     = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
      noisy   = (smp != 3'h0) && (smp != 3'h7);
      d       = nine ? s.rx_sh[9:1] : {1'b0, s.rx_sh[9:2]};
      // Ninth bit is either parity or the software bit
      if (nine) begin
         data_fr = {1'b1, pon ? (^s.tx_buf) ^ odd                // see RULE_01
                              : s.ctl3[`ASC_C3_T8],              // see RULE_16
                    s.tx_buf, 1'b0};
      end else begin
         data_fr = {2'b11, pon ? (^s.tx_buf[6:0]) ^ odd          // see RULE_01
                               : s.tx_buf[7],
                    s.tx_buf[6:0], 1'b0};
      end

      // APB setup phase: capture read data so it leaves a flop
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      if (psel && !penable) begin
         next_s.pready = 1'b1;
         next_s.prdata = 32'h0000_0000;
         case (idx)
            `ASC_IDX_CTL1: next_s.prdata[7:0] = s.ctl1;
            `ASC_IDX_CTL2: next_s.prdata[7:0] = s.ctl2;
            `ASC_IDX_CTL3: next_s.prdata[7:0] = s.ctl3;
            `ASC_IDX_STS1: next_s.prdata[7:0] = s.status;
            `ASC_IDX_DATA: next_s.prdata[7:0] = s.rx_buf;
            default:       next_s.pslverr = (paddr[1:0] == 2'h0);
         endcase
         if (paddr[1:0] != 2'h0) begin
            next_s.pslverr = 1'b1;
         end
      end

      // APB access phase: writes and read side effects
      if (acc && !s.pslverr) begin
         case (idx)
            `ASC_IDX_CTL1: begin
               if (pwrite) begin
                  next_s.ctl1 = pwdata[7:0];
               end
            end
            `ASC_IDX_CTL2: begin
               if (pwrite) begin
                  next_s.ctl2 = pwdata[7:0];
               end
            end
            `ASC_IDX_CTL3: begin
               if (pwrite) begin
                  next_s.ctl3 = (s.ctl3 & ~`ASC_C3_WMASK)
                              | (pwdata[7:0] & `ASC_C3_WMASK);
               end
            end
            `ASC_IDX_STS1: begin
               // Arm exactly the flags software saw
               if (!pwrite) begin
                  next_s.arm = s.prdata[7:0];
               end
            end
            `ASC_IDX_DATA: begin
               if (pwrite) begin
                  next_s.tx_buf = pwdata[7:0];
                  if (s.arm[`ASC_S1_TXE]) begin
                     next_s.status[`ASC_S1_TXE] = 1'b0;         // see RULE_18
                     next_s.arm[`ASC_S1_TXE]    = 1'b0;
                  end
               end else begin
                  // Unarmed flags survive a lone data read
                  next_s.status[5:0] = s.status[5:0] & ~s.arm[5:0]; // see RULE_21
                  next_s.arm[5:0]    = 6'h00;                   // see RULE_25
               end
            end
            default: ;
         endcase
      end

      // Transmitter enable edges
      if (!s.ctl2[`ASC_C2_TXON] && next_s.ctl2[`ASC_C2_TXON]) begin
         next_s.pend_pre = 1'b1;                                // see RULE_09
         if (!s.tx_ever) begin
            next_s.tx_ever = 1'b1;
            next_s.status[`ASC_S1_TXE] = 1'b1;                  // see RULE_19
         end
      end

      // Baud tick, halted while the block is off
      if (!en || tick) begin
         next_s.baud = 5'h00;
      end else begin
         next_s.baud = s.baud + 5'h01;
      end

      // ==========================================================
      // Transmitter
      // Block disable cuts the frame at once: the bit clock stops with it
      if (!(en && next_s.ctl1[`ASC_C1_EN])) begin
         next_s.tx_state   = asc_pkg::TX_IDLE;
         next_s.serial_out = ~inv;
         next_s.tx_is_brk  = 1'b0;
         next_s.pend_pre   = 1'b0;                              // see RULE_23
         next_s.brk_tail   = 1'b0;
      end else if (tick) begin
         if (s.tx_state == asc_pkg::TX_BUSY && s.tx_left != 4'h0) begin
            next_s.serial_out = s.tx_sh[0] ^ inv;
            next_s.tx_sh      = {1'b1, s.tx_sh[10:1]};
            next_s.tx_left    = s.tx_left - 4'h1;
         end else begin
            // Frame ended: chain the next one in the same tick
            next_s.tx_state   = asc_pkg::TX_IDLE;              // see RULE_08
            next_s.serial_out = ~inv;
            next_s.tx_is_brk  = 1'b0;
            if (s.ctl2[`ASC_C2_TXON]) begin
               have = 1'b1;
               if (s.pend_pre) begin
                  next_s.pend_pre = 1'b0;                       // see RULE_07
               end else if (s.ctl2[`ASC_C2_BRK]) begin
                  fr = 11'h000;                                 // see RULE_13
                  next_s.tx_is_brk = 1'b1;
                  next_s.brk_tail  = 1'b1;
               end else if (s.brk_tail) begin
                  next_s.brk_tail = 1'b0;                       // see RULE_13
                  flen = 4'h1;
               end else if (!s.status[`ASC_S1_TXE]) begin
                  fr = data_fr;                                 // see RULE_16
                  next_s.status[`ASC_S1_TXE] = 1'b1;            // see RULE_18
                  tx_load = 1'b1;
               end else begin
                  have = 1'b0;
               end
               if (have) begin
                  next_s.tx_state   = asc_pkg::TX_BUSY;
                  next_s.serial_out = fr[0] ^ inv;
                  next_s.tx_sh      = {1'b1, fr[10:1]};
                  next_s.tx_left    = flen - 4'h1;
               end
            end
         end
      end

      // Block disable forces both transmit flags
      if (s.ctl1[`ASC_C1_EN] && !next_s.ctl1[`ASC_C1_EN]) begin
         next_s.status[`ASC_S1_TXE] = 1'b1;                     // see RULE_23
      end
      next_s.status[`ASC_S1_TC] = next_s.status[`ASC_S1_TXE]    // see RULE_20
         && (!next_s.ctl1[`ASC_C1_EN]                           // see RULE_23
             || (next_s.tx_state == asc_pkg::TX_IDLE
                 && !next_s.pend_pre && !next_s.brk_tail
                 && !(next_s.ctl2[`ASC_C2_BRK]
                      && next_s.ctl2[`ASC_C2_TXON])));

      // ==========================================================
      // Receiver
      stby = s.ctl2[`ASC_C2_STBY];
      if (!(en && s.ctl2[`ASC_C2_RXON])) begin
         // Flags are left untouched on disable
         next_s.rx_state = asc_pkg::RX_IDLE;                    // see RULE_11
         next_s.idle_arm = 1'b0;
         next_s.ones     = 4'h0;
      end else begin
         case (s.rx_state)
            asc_pkg::RX_IDLE: begin
               if (!rxd) begin
                  next_s.rx_state = asc_pkg::RX_DATA;
                  next_s.rx_cnt   = 5'h00;
                  next_s.rx_bits  = 4'h0;
                  next_s.rx_noise = 1'b0;
                  next_s.ones     = 4'h0;
               end else if (tick && s.ones != frame_len) begin
                  next_s.ones = s.ones + 4'h1;
                  if (s.ones == frame_len - 4'h1) begin
                     if (s.idle_arm) begin
                        next_s.status[`ASC_S1_IDLE] = 1'b1;     // see RULE_22
                        next_s.idle_arm = 1'b0;
                     end
                     if (stby && !s.ctl1[`ASC_C1_WAKE]) begin
                        next_s.ctl2[`ASC_C2_STBY] = 1'b0;       // see RULE_24
                     end
                  end
               end
            end
            asc_pkg::RX_DATA: begin
               if (s.rx_cnt == `ASC_BIT_CYC - 5'h01) begin
                  next_s.rx_cnt  = 5'h00;
                  next_s.rx_bits = s.rx_bits + 4'h1;
               end else begin
                  next_s.rx_cnt = s.rx_cnt + 5'h01;
               end
               // Three samples around mid-bit vote on the value
               next_s.vote = {s.vote[0], rxd};
               if (s.rx_cnt == `ASC_HALF_CYC + 5'h01) begin
                  next_s.rx_noise = s.rx_noise | noisy;
                  if (s.rx_bits == 4'h0) begin
                     if (maj) begin
                        next_s.rx_state = asc_pkg::RX_IDLE;
                     end
                  end else if (s.rx_bits == frame_len - 4'h1) begin
                     next_s.rx_state = asc_pkg::RX_IDLE;
                     msb  = nine ? d[8] : d[7];
                     woke = stby && s.ctl1[`ASC_C1_WAKE] && msb;
                     if (woke) begin
                        next_s.ctl2[`ASC_C2_STBY] = 1'b0;       // see RULE_24
                     end
                     if (!stby || woke) begin
                        if (s.status[`ASC_S1_RXF]) begin
                           next_s.status[`ASC_S1_OR] = 1'b1;    // see RULE_25
                        end else begin
                           rx_xfer = 1'b1;
                           next_s.rx_buf = d[7:0];
                           next_s.ctl3[`ASC_C3_R8] = msb;       // see RULE_15
                           next_s.status[`ASC_S1_RXF] = 1'b1;   // see RULE_21
                           next_s.idle_arm = 1'b1;              // see RULE_22
                           if (!maj) begin
                              next_s.status[`ASC_S1_FE] = 1'b1;
                           end
                           if (pon && ((^d) ^ odd)) begin
                              next_s.status[`ASC_S1_PE] = 1'b1; // see RULE_01
                           end
                           if (s.rx_noise | noisy) begin
                              next_s.status[`ASC_S1_NF] = 1'b1;
                           end
                        end
                     end
                  end else begin
                     next_s.rx_sh = {maj, s.rx_sh[9:1]};
                  end
               end
            end
            default: next_s.rx_state = asc_pkg::RX_IDLE;
         endcase
      end

      // ==========================================================
      // Interrupt requests, registered
      next_s.irq_tx = next_s.ctl1[`ASC_C1_EN] && (              // see RULE_26
         (next_s.status[`ASC_S1_TXE] && next_s.ctl2[`ASC_C2_TXE_IE])
         || (next_s.status[`ASC_S1_TC]                          // see RULE_05
             && next_s.ctl2[`ASC_C2_TXD_IE]));                  // see RULE_04
      next_s.irq_rx = !next_s.ctl2[`ASC_C2_STBY] && (           // see RULE_12
         (next_s.status[`ASC_S1_RXF] && next_s.ctl2[`ASC_C2_RXF_IE])
         || (next_s.status[`ASC_S1_IDLE]                        // see RULE_06
             && next_s.ctl2[`ASC_C2_IDL_IE]));
      next_s.irq_err = |(next_s.status[3:0] & next_s.ctl3[3:0]); // see RULE_17
   end

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s            <= '0;
         s.status     <= `ASC_S1_RESET;
         s.serial_out <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Checks
   sequence seq_tx_enable;
      $rose(s.ctl2[`ASC_C2_TXON]) && en && !inv
         && s.tx_state == asc_pkg::TX_IDLE;
   endsequence

   sequence seq_line_high;
      serial_out_pin [*8];
   endsequence

   a_preamble_high: assert property ( // see RULE_07
      @(posedge pclk) disable iff (!presetn)
      seq_tx_enable |=> seq_line_high)
      else $error("preamble not high after transmitter enable");

   a_tx_irq_gate: assert property ( // see RULE_04
      @(posedge pclk) disable iff (!presetn)
      (!s.ctl2[`ASC_C2_TXE_IE] && !s.ctl2[`ASC_C2_TXD_IE]) |-> !irq_tx)
      else $error("transmit interrupt without enable");

   a_rx_standby_mask: assert property ( // see RULE_12
      @(posedge pclk) disable iff (!presetn)
      s.ctl2[`ASC_C2_STBY] |-> !irq_rx)
      else $error("receive interrupt during standby");

   a_err_irq_gate: assert property ( // see RULE_17
      @(posedge pclk) disable iff (!presetn)
      (s.ctl3[3:0] == 4'h0) |-> !irq_err)
      else $error("error interrupt with all enables off");

   a_load_sets_empty: assert property ( // see RULE_18
      @(posedge pclk) disable iff (!presetn)
      tx_load |=> s.status[`ASC_S1_TXE] && s.tx_state == asc_pkg::TX_BUSY)
      else $error("empty flag not set on buffer load");

   a_done_needs_empty: assert property ( // see RULE_20
      @(posedge pclk) disable iff (!presetn)
      s.status[`ASC_S1_TC] |-> s.status[`ASC_S1_TXE]
         && s.tx_state == asc_pkg::TX_IDLE)
      else $error("done flag while busy or not empty");

   a_break_low: assert property ( // see RULE_13
      @(posedge pclk) disable iff (!presetn)
      (s.tx_is_brk && s.tx_state == asc_pkg::TX_BUSY)
         |-> serial_out_pin == inv)
      else $error("line not low during break");

   a_full_on_xfer: assert property ( // see RULE_21
      @(posedge pclk) disable iff (!presetn)
      rx_xfer |=> s.status[`ASC_S1_RXF] && s.rx_buf == $past(d[7:0]))
      else $error("receive full not set on transfer");

   a_overrun_kept: assert property ( // see RULE_25
      @(posedge pclk) disable iff (!presetn)
      (acc && !pwrite && idx == `ASC_IDX_DATA && !s.arm[`ASC_S1_OR]
         && s.status[`ASC_S1_OR]) |=> s.status[`ASC_S1_OR])
      else $error("overrun cleared without armed status read");

   a_disable_flags: assert property ( // see RULE_23
      @(posedge pclk) disable iff (!presetn)
      $fell(s.ctl1[`ASC_C1_EN]) |-> s.status[`ASC_S1_TXE]
         && s.status[`ASC_S1_TC] && !irq_tx)
      else $error("block disable did not set transmit flags");

endmodule

// ===== testbench/asc_remote.sv
`timescale 1ns/1ns

// ==========================================
// Far-end serial transceiver, 16 pclk per bit
module asc_remote (
   // Clock
   input  wire logic       pclk,
   // Line from the block
   input  wire logic       line_in,
   // Send request
   input  wire logic       send,
   input  wire logic [7:0] send_byte,
   // Line to the block and captured frames
   output logic            line_out,
   output logic            busy,
   output logic [9:0]      heard,
   output logic [7:0]      frames
);
   logic [9:0] h;

   initial begin
      line_out = 1'b1;
      busy = 1'b0;
      heard = 10'h000;
      frames = 8'h00;
   end

   // Start, eight data bits LSB first, stop
   always @(posedge pclk) begin
      if (send) begin
         busy <= 1'b1;
         for (int i = 0; i < 10; i++) begin
            line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : send_byte[i-1];
            repeat (16) @(posedge pclk);
         end
         busy <= 1'b0;
      end
   end

   // Sample each bit at its centre
   always begin
      @(negedge line_in);
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 10; i++) begin
         h[i] = line_in;
         if (i < 9) repeat (16) @(posedge pclk);
      end
      heard <= h;
      frames <= frames + 8'h01;
   end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ns
`include "asc_cfg.svh"

module testbench;
   // ==========================================
   // Signals
   logic        pclk, presetn, psel, penable, pwrite, send, serr;
   logic [7:0]  paddr, sbyte, q, b;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, rxd, txd, busy;
   logic        irq_tx, irq_rx, irq_err;
   logic [9:0]  heard;
   logic [7:0]  frames;
   logic [7:0]  rxq[$];
   int          num_errors, comparisons, n;
   localparam logic [7:0] C1 = {`ASC_IDX_CTL1, 2'b00};
   localparam logic [7:0] C2 = {`ASC_IDX_CTL2, 2'b00};
   localparam logic [7:0] C3 = {`ASC_IDX_CTL3, 2'b00};
   localparam logic [7:0] ST = {`ASC_IDX_STS1, 2'b00};
   localparam logic [7:0] DT = {`ASC_IDX_DATA, 2'b00};

   asc_serial_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_in_pin(rxd), .serial_out_pin(txd), .irq_tx(irq_tx),
      .irq_rx(irq_rx), .irq_err(irq_err));
   asc_remote far (.pclk(pclk), .line_in(txd), .send(send),
      .send_byte(sbyte), .line_out(rxd), .busy(busy), .heard(heard),
      .frames(frames));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ==========================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // One APB transfer, waits for pready with a bound
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) num_errors++;
      q = prdata[7:0];
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic far_send(input logic [7:0] v);
      sbyte <= v;
      send <= 1'b1;
      rxq.push_back(v);
      @(posedge pclk);
      send <= 1'b0;
      n = 0;
      @(posedge pclk);
      while (busy && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 400) num_errors++;
      repeat (20) @(posedge pclk);
   endtask

   // Waits until the far end has captured one more frame
   task automatic wait_frame;
      logic [7:0] f0;
      int         w;
      f0 = frames;
      w = 0;
      while (frames == f0 && w < 600) begin
         @(posedge pclk);
         w++;
      end
      if (w >= 600) num_errors++;
   endtask

   task automatic finish_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #300000;
      num_errors++;
      finish_test;
   end

   // ==========================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, send, presetn} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      sbyte = 8'h00;
      num_errors = 0;
      comparisons = 0;
      void'($urandom(6595));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, ST, 0); chk(q, 8'hC0);
      apb(0, C2, 0); chk(q, 8'h00);
      chk({5'h0, irq_tx, irq_rx, irq_err}, 8'h00);
      apb(0, 8'hFC, 0); chk({7'h0, serr}, 8'h01);
      // Block enabled before any enable write
      apb(1, C1, 8'h40);
      apb(1, C2, 8'h88);
      chk({7'h0, irq_tx}, 8'h01);
      n = 0;
      repeat (150) begin
         @(posedge pclk);
         if (txd !== 1'b1) n++;
      end
      chk(n[7:0], 8'h00);
      // Parity changed only between characters
      for (int m = 0; m < 3; m++) begin
         b = 8'($urandom);
         apb(1, C1, 8'h40 | {6'h0, m != 0, m == 2});
         apb(0, ST, 0);
         apb(1, DT, b);
         wait_frame;
         if (m != 0) b[7] = (m == 2) ? ~^b[6:0] : ^b[6:0];
         chk(heard[8:1], b);
         chk({6'h0, heard[9], heard[0]}, 8'h02);
         repeat (20) @(posedge pclk);
         apb(0, ST, 0); chk(q, 8'hC0);
      end
      // Break long after the empty flag last set
      apb(1, C2, 8'h09);
      repeat (40) @(posedge pclk);
      apb(1, C2, 8'h08);
      wait_frame;
      chk(heard[7:0], 8'h00);
      chk({6'h0, heard[9:8]}, 8'h00);
      repeat (40) @(posedge pclk);
      chk({7'h0, txd}, 8'h01);
      apb(1, C2, 8'h48); chk({7'h0, irq_tx}, 8'h01);
      apb(1, C2, 8'h08); chk({7'h0, irq_tx}, 8'h00);
      apb(1, C1, 8'h40);
      apb(1, C2, 8'h2C);
      far_send(8'($urandom) | 8'h80);
      chk({7'h0, irq_rx}, 8'h01);
      repeat (200) @(posedge pclk);
      apb(0, ST, 0); chk(q & 8'h30, 8'h30);
      apb(0, C3, 0); chk(q & 8'h80, rxq[0] & 8'h80);
      apb(0, DT, 0); chk(q, rxq.pop_front());
      chk({7'h0, irq_rx}, 8'h00);
      far_send(8'($urandom));
      far_send(8'($urandom));
      apb(0, DT, 0); chk(q, rxq.pop_front());
      void'(rxq.pop_front());
      apb(0, ST, 0); chk(q & 8'h28, 8'h28);
      apb(1, C3, 8'h08); chk({7'h0, irq_err}, 8'h01);
      apb(0, DT, 0);
      apb(0, ST, 0); chk(q & 8'h28, 8'h00);
      // Block disable right after queueing data
      apb(1, C2, 8'hAC); chk({7'h0, irq_tx}, 8'h01);
      apb(0, ST, 0);
      apb(1, DT, 8'($urandom));
      apb(1, C1, 8'h00); chk({7'h0, irq_tx}, 8'h00);
      apb(0, ST, 0); chk(q & 8'hC0, 8'hC0);
      finish_test;
   end
endmodule
